// ===== rtl/rtu_rotate_unit.sv
module rtu_rotate_unit
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [1:0] op,
  input  wire logic [7:0] mem_in,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            mem_we,
  output logic            acc_we,
  output logic            carry_out,
  output logic            carry_we,
  output logic            done
);

  // All state of the unit
  typedef struct packed
  {
    rtu_pkg::rtu_state_t state;
    logic [7:0]          result;
    logic                mem_we;
    logic                acc_we;
    logic                carry_out;
    logic                carry_we;
  } rtu_regs_t;

  rtu_regs_t r;
  rtu_regs_t next_r;

  // Decode the operation and form the rotated byte
  always_comb
  begin
    next_r          = r;
    next_r.mem_we   = 1'b0;
    next_r.acc_we   = 1'b0;
    next_r.carry_we = 1'b0;
    next_r.state    = rtu_pkg::RTU_IDLE;
    if (start)
    begin
      next_r.state = rtu_pkg::RTU_DONE;
      case (op)
        rtu_pkg::OP_ROTATE_LEFT_THROUGH_CY_TO_ACC:
        begin
          next_r.result    = {mem_in[6:0], carry_in};
          next_r.carry_out = mem_in[7];
          next_r.carry_we  = 1'b1;
          next_r.acc_we    = 1'b1;
        end
        rtu_pkg::OP_ROTATE_RIGHT_IN_PLACE:
        begin
          next_r.result = {mem_in[0], mem_in[7:1]};
          next_r.mem_we = 1'b1;
        end
        rtu_pkg::OP_ROTATE_RIGHT_TO_ACC:
        begin
          next_r.result = {mem_in[0], mem_in[7:1]};
          next_r.acc_we = 1'b1;
        end
        rtu_pkg::OP_ROTATE_RIGHT_THROUGH_CY:
        begin
          next_r.result    = {carry_in, mem_in[7:1]};
          next_r.carry_out = mem_in[0];
          next_r.carry_we  = 1'b1;
          next_r.mem_we    = 1'b1;
        end
        default:
        begin
          next_r.state = rtu_pkg::RTU_IDLE;
        end
      endcase
    end
  end

  // Register the whole state
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      r.state     <= rtu_pkg::RTU_IDLE;
      r.result    <= rtu_pkg::RESET_BYTE;
      r.mem_we    <= 1'b0;
      r.acc_we    <= 1'b0;
      r.carry_out <= rtu_pkg::RESET_CARRY;
      r.carry_we  <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign result    = r.result;
  assign mem_we    = r.mem_we;
  assign acc_we    = r.acc_we;
  assign carry_out = r.carry_out;
  assign carry_we  = r.carry_we;
  assign done      = r.state[1]; // Done bit of the one-hot state

  // An op taken at an edge, one sequence per operation
  sequence s_take_left_cy;
    start && op == rtu_pkg::OP_ROTATE_LEFT_THROUGH_CY_TO_ACC;
  endsequence

  sequence s_take_right_mem;
    start && op == rtu_pkg::OP_ROTATE_RIGHT_IN_PLACE;
  endsequence

  sequence s_take_right_acc;
    start && op == rtu_pkg::OP_ROTATE_RIGHT_TO_ACC;
  endsequence

  sequence s_take_right_cy;
    start && op == rtu_pkg::OP_ROTATE_RIGHT_THROUGH_CY;
  endsequence

  // Rotates that bypass carry
  sequence s_take_plain;
    start && (op == rtu_pkg::OP_ROTATE_RIGHT_IN_PLACE
              || op == rtu_pkg::OP_ROTATE_RIGHT_TO_ACC);
  endsequence

  // Rotates through carry
  sequence s_take_through_cy;
    start && (op == rtu_pkg::OP_ROTATE_LEFT_THROUGH_CY_TO_ACC
              || op == rtu_pkg::OP_ROTATE_RIGHT_THROUGH_CY);
  endsequence

  // Strobes of the cycle that answers a start
  sequence s_answer_acc;
    done && acc_we && !mem_we;
  endsequence

  sequence s_answer_mem;
    done && mem_we && !acc_we;
  endsequence

  // Left rotate through carry lands in the accumulator
  a_left_cy_acc: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_left_cy |=>
      result == {$past(mem_in[6:0]), $past(carry_in)})
    else $error("left rotate through carry wrong");

  a_left_cy_out: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_left_cy |=> carry_out == $past(mem_in[7]))
    else $error("left rotate carry wrong");

  // The memory byte is never written by the left rotate
  a_left_target: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_left_cy |=> s_answer_acc)
    else $error("left rotate wrote memory");

  // Right rotate in place
  a_right_place: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_right_mem |=>
      result == {$past(mem_in[0]), $past(mem_in[7:1])})
    else $error("right rotate in place wrong");

  a_right_place_we: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_right_mem |=> s_answer_mem)
    else $error("right rotate in place not written back");

  // Right rotate into the accumulator, memory kept
  a_right_acc: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_right_acc |=>
      result == {$past(mem_in[0]), $past(mem_in[7:1])})
    else $error("right rotate to acc wrong");

  a_right_acc_we: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_right_acc |=> s_answer_acc)
    else $error("right rotate to acc wrote memory");

  // Right rotate through carry, written back in place
  a_right_cy: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_right_cy |=>
      result == {$past(carry_in), $past(mem_in[7:1])}
      && carry_out == $past(mem_in[0]))
    else $error("right rotate through carry wrong");

  a_right_cy_we: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_right_cy |=> s_answer_mem)
    else $error("right rotate through carry not written back");

  // Carry is written by the through-carry rotates only
  a_flags_kept: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_plain |=> !carry_we)
    else $error("carry written by plain rotate");

  a_carry_written: assert property (
    @(posedge clock) disable iff (!resetn)
    s_take_through_cy |=> carry_we)
    else $error("carry not written by carry rotate");

  // Carry moves only with its write strobe or a reset
  a_carry_hold: assert property (
    @(posedge clock) disable iff (!resetn)
    !carry_we && $past(resetn) |-> $stable(carry_out))
    else $error("carry changed without write");

  // Result holds between starts
  a_result_hold: assert property (
    @(posedge clock) disable iff (!resetn)
    !start && resetn |=> $stable(result))
    else $error("result changed without start");

  // Every start gets one done pulse, nothing strobes otherwise
  a_done_follows: assert property (
    @(posedge clock) disable iff (!resetn)
    start |=> done)
    else $error("start not answered");

  a_done_pulse: assert property (
    @(posedge clock) disable iff (!resetn)
    !start |=> !done && !mem_we && !acc_we && !carry_we)
    else $error("strobe without start");

  a_strobe_done: assert property (
    @(posedge clock) disable iff (!resetn)
    mem_we || acc_we || carry_we |-> done)
    else $error("write strobe without done");

  // Synchronous reset clears every output
  a_reset_clear: assert property (
    @(posedge clock)
    !resetn |=> result == rtu_pkg::RESET_BYTE
      && carry_out == rtu_pkg::RESET_CARRY
      && !done && !mem_we && !acc_we && !carry_we)
    else $error("outputs not cleared by reset");

endmodule

// ===== rtl/rtu_pkg.sv
package rtu_pkg;

  // Datapath width
  localparam int unsigned DATA_W = 8;

  // Operation select codes on the op input
  localparam logic [1:0] OP_ROTATE_LEFT_THROUGH_CY_TO_ACC = 2'h0;
  localparam logic [1:0] OP_ROTATE_RIGHT_IN_PLACE         = 2'h1;
  localparam logic [1:0] OP_ROTATE_RIGHT_TO_ACC           = 2'h2;
  localparam logic [1:0] OP_ROTATE_RIGHT_THROUGH_CY       = 2'h3;

  // Reset values of the registered outputs
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic       RESET_CARRY = 1'b0;

  // One-hot states of the result stage
  typedef enum logic [1:0]
  {
    RTU_IDLE = 2'b01,
    RTU_DONE = 2'b10
  } rtu_state_t;

endpackage

// ===== bench/rtu_rotate_unit_tb.sv
module rtu_rotate_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic       start = 1'b0;
  logic [1:0] op = 2'h0;
  logic [7:0] mem_in = 8'h00;
  logic       carry_in = 1'b0;
  logic [7:0] result;
  logic       mem_we, acc_we, carry_out, carry_we, done;
  int         n_errors = 0;
  int         tests_run = 0;

  // Short names for the op codes
  localparam logic [1:0] OP_LEFT_CY =
    rtu_pkg::OP_ROTATE_LEFT_THROUGH_CY_TO_ACC;
  localparam logic [1:0] OP_RIGHT_MEM =
    rtu_pkg::OP_ROTATE_RIGHT_IN_PLACE;
  localparam logic [1:0] OP_RIGHT_ACC =
    rtu_pkg::OP_ROTATE_RIGHT_TO_ACC;
  localparam logic [1:0] OP_RIGHT_CY =
    rtu_pkg::OP_ROTATE_RIGHT_THROUGH_CY;

  // Core clock, 25 ns period
  always #12.5 clock = ~clock;

  rtu_rotate_unit rtu_rotate_unit_inst
  (
    .clock(clock), .resetn(resetn), .start(start), .op(op),
    .mem_in(mem_in), .carry_in(carry_in), .result(result),
    .mem_we(mem_we), .acc_we(acc_we), .carry_out(carry_out),
    .carry_we(carry_we), .done(done)
  );

  // Compares one value and counts it
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Issues one op, then judges result, strobes and carry
  // Strobe order: mem_we, acc_we, carry_we, done
  task exec(input logic [1:0] o, input logic [7:0] m, input logic c,
            input logic [7:0] r, input logic [3:0] we, input logic cy);
    @(posedge clock);
    start <= 1'b1;
    op <= o;
    mem_in <= m;
    carry_in <= c;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    check(result, r);
    check({4'h0, mem_we, acc_we, carry_we, done}, {4'h0, we});
    check({7'h00, carry_out}, {7'h00, cy});
    // No start, so every strobe must have dropped
    @(negedge clock);
    check({4'h0, mem_we, acc_we, carry_we, done}, 8'h00);
  endtask

  // Idle values after reset
  task t_reset;
    @(negedge clock);
    check(result, rtu_pkg::RESET_BYTE);
    check({7'h00, carry_out}, {7'h00, rtu_pkg::RESET_CARRY});
    check({4'h0, mem_we, acc_we, carry_we, done}, 8'h00);
  endtask

  // Left through carry into the accumulator
  task t_left_cy;
    exec(OP_LEFT_CY, 8'h81, 1'b1, 8'h03, 4'h7, 1'b1);
    exec(OP_LEFT_CY, 8'h7e, 1'b0, 8'hfc, 4'h7, 1'b0);
  endtask

  // Right in place; carry must hold its last value
  task t_right_place;
    exec(OP_RIGHT_MEM, 8'h81, 1'b1, 8'hc0, 4'h9, 1'b0);
    exec(OP_RIGHT_MEM, 8'h02, 1'b1, 8'h01, 4'h9, 1'b0);
  endtask

  // Right into the accumulator; memory never written
  task t_right_acc;
    exec(OP_RIGHT_ACC, 8'h01, 1'b1, 8'h80, 4'h5, 1'b0);
  endtask

  // Right through carry, both carry directions
  task t_right_cy;
    exec(OP_RIGHT_CY, 8'h81, 1'b0, 8'h40, 4'hb, 1'b1);
    exec(OP_RIGHT_CY, 8'h00, 1'b1, 8'h80, 4'hb, 1'b0);
  endtask

  // Plain rotates keep a carry of one
  task t_carry_kept;
    exec(OP_RIGHT_CY, 8'h01, 1'b0, 8'h00, 4'hb, 1'b1);
    exec(OP_RIGHT_MEM, 8'h10, 1'b0, 8'h08, 4'h9, 1'b1);
    exec(OP_RIGHT_ACC, 8'h03, 1'b0, 8'h81, 4'h5, 1'b1);
  endtask

  // Reset in mid-run clears result, carry and strobes
  task t_reset_mid;
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    check(result, rtu_pkg::RESET_BYTE);
    check({7'h00, carry_out}, {7'h00, rtu_pkg::RESET_CARRY});
    check({4'h0, mem_we, acc_we, carry_we, done}, 8'h00);
  endtask

  // Two ops on adjacent edges, each answered one cycle later
  task t_back_to_back;
    @(posedge clock);
    start <= 1'b1;
    op <= OP_RIGHT_MEM;
    mem_in <= 8'h81;
    carry_in <= 1'b0;
    @(posedge clock);
    op <= OP_LEFT_CY;
    mem_in <= 8'h40;
    carry_in <= 1'b1;
    @(negedge clock);
    check(result, 8'hc0);
    check({4'h0, mem_we, acc_we, carry_we, done}, 8'h09);
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    check(result, 8'h81);
    check({4'h0, mem_we, acc_we, carry_we, done}, 8'h07);
    check({7'h00, carry_out}, 8'h00);
    @(negedge clock);
    check({4'h0, mem_we, acc_we, carry_we, done}, 8'h00);
  endtask

  // Prints the verdict and ends the run
  task wrap_up;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_left_cy();
    t_right_place();
    t_right_acc();
    t_right_cy();
    t_carry_kept();
    t_reset_mid();
    t_back_to_back();
    wrap_up();
  end

  // Watchdog
  initial
  begin
    #10000;
    n_errors++;
    wrap_up();
  end
endmodule
